// [rtl/ioc_cfg_pkg.sv]
// shared constants and carrier types of the change-compare and configuration slice
package ioc_cfg_pkg;

    // ------------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DEFAULT_COMPARE = 8'h03;
    localparam logic [7:0] ADDR_COMPARE_MODE    = 8'h04;
    localparam logic [7:0] ADDR_DEVICE_CONFIG   = 8'h05;
    localparam logic [7:0] RST_DEFAULT_COMPARE  = 8'h00;
    localparam logic [7:0] RST_COMPARE_MODE     = 8'h00;

    // ------------------------------------------------------------------
    // device configuration field positions
    // ------------------------------------------------------------------
    localparam int CFG_POINTER_HOLD  = 5;
    localparam int CFG_SDA_LIMIT_OFF = 4;
    localparam int CFG_ADDR_PIN_EN   = 3;
    localparam int CFG_IRQ_OPEN_DRN  = 2;
    localparam int CFG_IRQ_POLARITY  = 1;

    // implemented configuration bits, packed in register order 5..1
    typedef struct packed {
        logic pointer_hold;
        logic sda_edge_limit_off;
        logic addr_pin_enable;
        logic irq_open_drain;
        logic irq_polarity;
    } cfg_s;

    localparam cfg_s RST_DEVICE_CONFIG = '0;

    // register port request from the serial engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage

// [rtl/ioc_pin_track.sv]
// two-flop synchroniser for outside levels plus the previously seen level
module ioc_pin_track #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] pins_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] prev_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] prev;
        logic [2:0]       fill;
    } track_s;

    track_s s_q;
    track_s s_d;

    // ------------------------------------------------------------------
    // next state: meta is read only by level, prev lags level by a cycle
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.meta  = pins_i;
        s_d.level = s_q.meta;
        s_d.prev  = s_q.level;
        s_d.fill  = {s_q.fill[1:0], 1'b1};
    end

    // registers; the chain clears on reset and refills from the pins over three cycles
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;
    // a pin idling high would otherwise look like a change right after reset
    assign prev_o  = s_q.fill[2] ? s_q.prev : s_q.level;

endmodule

// [rtl/ioc_compare_cfg.sv]
// interrupt-on-change compare registers, device configuration and interrupt pin drive
//
// What this block does
// - an enabled pin in default-compare mode raises the interrupt when its level is opposite its default bit.
// - the default-compare register is at 0x03, eight read/write bits, zero after reset.
// - a compare-select bit of one compares that pin against its default-compare bit.
// - a compare-select bit of zero compares that pin against its previous level, so any change is an event.
// - the compare-select register is at 0x04, eight read/write bits, zero after reset.
// - configuration bit 5 set holds the address pointer, clear lets it advance after each byte.
// - configuration bit 4 clear enables falling-edge slew control on serial data, set disables it.
// - on the SPI variant, configuration bit 3 set compares the address pins with the control byte, clear ignores them.
// - on the I2C variant, configuration bit 3 has no effect and the address pins always take part.
// - configuration bit 2 set makes the interrupt pin open-drain and ignores polarity, clear drives it actively.
// - configuration bit 1 selects active-high when set and active-low when clear, only while bit 2 is clear.
// - configuration bits 7, 6 and 0 ignore writes and read as zero.
// - a pin causes a change interrupt only while its change-interrupt enable bit is set.
// - only pins configured as inputs can raise the interrupt.
// - in previous-level mode the new level becomes the reference once the event is seen.
// - in default-compare mode the interrupt persists while the mismatch exists, even across a clear.
module ioc_compare_cfg #(
    parameter bit SPI_VARIANT = 1'b1,
    parameter int PINS        = 8,
    parameter int ADDR_PINS   = 2
) (
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    input  wire ioc_cfg_pkg::reg_req_s    reg_req_i,
    output logic      [7:0]               reg_rdata_o,
    input  wire logic [PINS-1:0]          port_pins_i,
    input  wire logic [PINS-1:0]          pin_is_input_i,
    input  wire logic [PINS-1:0]          change_irq_enable_i,
    input  wire logic                     irq_clear_i,
    input  wire logic                     byte_done_i,
    output logic                          ptr_advance_o,
    input  wire logic [ADDR_PINS-1:0]     addr_pins_i,
    input  wire logic                     ctrl_valid_i,
    input  wire logic [ADDR_PINS-1:0]     ctrl_addr_i,
    output logic                          addr_match_o,
    output logic                          sda_slew_en_o,
    output logic                          irq_pending_o,
    output logic                          irq_pin_o,
    output logic                          irq_pin_oe_n_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PINS-1:0]    default_compare;
        logic [PINS-1:0]    compare_mode_select;
        ioc_cfg_pkg::cfg_s  cfg;
        logic               irq;
        logic               irq_pin;
        logic               irq_pin_oe_n;
        logic [7:0]         rdata;
        logic               addr_match;
        logic               ptr_adv;
        logic               slew_en;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [PINS-1:0]      pin_level;
    logic [PINS-1:0]      pin_prev;
    logic [ADDR_PINS-1:0] addr_level;
    logic [PINS-1:0]      pin_event;

    // ------------------------------------------------------------------
    // synchronise the port and the address straps
    // ------------------------------------------------------------------
    ioc_pin_track #(.WIDTH(PINS)) u_port_track (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pins_i    (port_pins_i),
        .level_o   (pin_level),
        .prev_o    (pin_prev)
    );

    ioc_pin_track #(.WIDTH(ADDR_PINS)) u_addr_track (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pins_i    (addr_pins_i),
        .level_o   (addr_level),
        .prev_o    ()
    );

    // per-pin interrupt condition
    function automatic logic [PINS-1:0] pin_events(
        input logic [PINS-1:0] en,
        input logic [PINS-1:0] is_in,
        input logic [PINS-1:0] mode,
        input logic [PINS-1:0] dflt,
        input logic [PINS-1:0] lvl,
        input logic [PINS-1:0] prev
    );
        logic [PINS-1:0] ref_lvl;
        ref_lvl    = (mode & dflt) | (~mode & prev);
        pin_events = en & is_in & (lvl ^ ref_lvl);
    endfunction

    // the previous level follows the pin each cycle, so a change is seen once and then becomes the reference
    assign pin_event = pin_events(change_irq_enable_i, pin_is_input_i, s_q.compare_mode_select,
                                  s_q.default_compare, pin_level, pin_prev);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // register writes; unimplemented configuration bits have no storage
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ioc_cfg_pkg::ADDR_DEFAULT_COMPARE: s_d.default_compare = reg_req_i.wdata[PINS-1:0];
                ioc_cfg_pkg::ADDR_COMPARE_MODE:    s_d.compare_mode_select = reg_req_i.wdata[PINS-1:0];
                ioc_cfg_pkg::ADDR_DEVICE_CONFIG:
                    s_d.cfg = reg_req_i.wdata[ioc_cfg_pkg::CFG_POINTER_HOLD:ioc_cfg_pkg::CFG_IRQ_POLARITY];
                default: ;
            endcase
        end
        // register reads; bits 7, 6, 0 of the configuration read as zero
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ioc_cfg_pkg::ADDR_DEFAULT_COMPARE: s_d.rdata = 8'(s_q.default_compare);
                ioc_cfg_pkg::ADDR_COMPARE_MODE:    s_d.rdata = 8'(s_q.compare_mode_select);
                ioc_cfg_pkg::ADDR_DEVICE_CONFIG:   s_d.rdata = {2'b00, s_q.cfg, 1'b0};
                default:                           s_d.rdata = 8'h00;
            endcase
        end
        // pending interrupt: a live event wins over the clear, which keeps default mismatches alive
        if (|pin_event) begin
            s_d.irq = 1'b1;
        end else if (irq_clear_i) begin
            s_d.irq = 1'b0;
        end
        // pin drive follows the next pending state and next configuration together
        if (s_d.cfg.irq_open_drain) begin
            s_d.irq_pin      = 1'b0;
            s_d.irq_pin_oe_n = ~s_d.irq;
        end else begin
            s_d.irq_pin      = s_d.cfg.irq_polarity ? s_d.irq : ~s_d.irq;
            s_d.irq_pin_oe_n = 1'b0;
        end
        // pointer advance after each byte unless held
        s_d.ptr_adv = byte_done_i & ~s_q.cfg.pointer_hold;
        s_d.slew_en = ~s_d.cfg.sda_edge_limit_off;
        // hardware address compare
        if (ctrl_valid_i) begin
            if (SPI_VARIANT) begin
                s_d.addr_match = ~s_q.cfg.addr_pin_enable | (ctrl_addr_i == addr_level);
            end else begin
                s_d.addr_match = (ctrl_addr_i == addr_level);
            end
        end
    end

    // registers; reset drives the interrupt pin inactive active-low push-pull
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q                     <= '0;
            s_q.default_compare     <= ioc_cfg_pkg::RST_DEFAULT_COMPARE[PINS-1:0];
            s_q.compare_mode_select <= ioc_cfg_pkg::RST_COMPARE_MODE[PINS-1:0];
            s_q.cfg                 <= ioc_cfg_pkg::RST_DEVICE_CONFIG;
            s_q.irq_pin             <= 1'b1;
            s_q.slew_en             <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o    = s_q.rdata;
    assign ptr_advance_o  = s_q.ptr_adv;
    assign addr_match_o   = s_q.addr_match;
    assign sda_slew_en_o  = s_q.slew_en;
    assign irq_pending_o  = s_q.irq;
    assign irq_pin_o      = s_q.irq_pin;
    assign irq_pin_oe_n_o = s_q.irq_pin_oe_n;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_default_mismatch;
        @(posedge clk_i) disable iff (sys_rst_i)
        (|(change_irq_enable_i & pin_is_input_i & s_q.compare_mode_select & (pin_level ^ s_q.default_compare)))
        |=> irq_pending_o;
    endproperty
    a_default_mismatch: assert property (p_default_mismatch) else $error("default mismatch missed");

    property p_prev_change;
        @(posedge clk_i) disable iff (sys_rst_i)
        (|(change_irq_enable_i & pin_is_input_i & ~s_q.compare_mode_select & (pin_level ^ pin_prev)))
        |=> irq_pending_o;
    endproperty
    a_prev_change: assert property (p_prev_change) else $error("level change missed");

    property p_regs_reset;
        @(posedge clk_i) $fell(sys_rst_i) |-> s_q.default_compare == '0 && s_q.compare_mode_select == '0;
    endproperty
    a_regs_reset: assert property (p_regs_reset) else $error("compare registers not cleared by reset");

    property p_pointer_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        byte_done_i && s_q.cfg.pointer_hold |=> !ptr_advance_o;
    endproperty
    a_pointer_hold: assert property (p_pointer_hold) else $error("pointer advanced while held");

    property p_slew;
        @(posedge clk_i) disable iff (sys_rst_i)
        sda_slew_en_o == !s_q.cfg.sda_edge_limit_off;
    endproperty
    a_slew: assert property (p_slew) else $error("slew control disagrees with configuration");

    property p_spi_addr_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        SPI_VARIANT && ctrl_valid_i && !s_q.cfg.addr_pin_enable |=> addr_match_o;
    endproperty
    a_spi_addr_off: assert property (p_spi_addr_off) else $error("address pins used while disabled");

    property p_i2c_addr;
        @(posedge clk_i) disable iff (sys_rst_i)
        !SPI_VARIANT && ctrl_valid_i && (ctrl_addr_i != addr_level) |=> !addr_match_o;
    endproperty
    a_i2c_addr: assert property (p_i2c_addr) else $error("address pins ignored on i2c variant");

    property p_cfg_read;
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.rd && reg_req_i.addr == ioc_cfg_pkg::ADDR_DEVICE_CONFIG
        |=> reg_rdata_o[7:6] == 2'b00 && reg_rdata_o[0] == 1'b0;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("unimplemented configuration bits read nonzero");

    property p_open_drain;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_q.cfg.irq_open_drain |-> !irq_pin_o && (irq_pin_oe_n_o == !irq_pending_o);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

    property p_push_pull;
        @(posedge clk_i) disable iff (sys_rst_i)
        !s_q.cfg.irq_open_drain |-> !irq_pin_oe_n_o && (irq_pin_o == (s_q.cfg.irq_polarity ~^ irq_pending_o));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull level wrong");

    property p_hold_default;
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_clear_i && (|(change_irq_enable_i & pin_is_input_i & s_q.compare_mode_select &
                          (pin_level ^ s_q.default_compare))) |=> irq_pending_o;
    endproperty
    a_hold_default: assert property (p_hold_default) else $error("clear dropped a live mismatch");

endmodule

// [verif/host_model.sv]
// host-side model: register requests, byte strobes and control-byte address
module host_model (
    input  wire logic             clk_i,
    output ioc_cfg_pkg::reg_req_s reg_req_o,
    input  wire logic [7:0]       reg_rdata_i,
    output logic                  byte_done_o,
    output logic                  ctrl_valid_o,
    output logic [1:0]            ctrl_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------------
    initial begin
        reg_req_o = '0;
        byte_done_o = 1'b0;
        ctrl_valid_o = 1'b0;
        ctrl_addr_o = 2'b00;
    end

    // ------------------------------------------------------------------
    // bus cycles: one-cycle strobes; released fields show the inverse, never the old value
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(posedge clk_i);
        d = reg_rdata_i;
    endtask

    task automatic pulse_byte();
        @(posedge clk_i);
        byte_done_o <= 1'b1;
        @(posedge clk_i);
        byte_done_o <= 1'b0;
    endtask

    task automatic ctrl(input logic [1:0] a);
        @(posedge clk_i);
        ctrl_valid_o <= 1'b1;
        ctrl_addr_o <= a;
        @(posedge clk_i);
        ctrl_valid_o <= 1'b0;
        ctrl_addr_o <= ~a;
    endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the change-compare and configuration slice
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    ioc_cfg_pkg::reg_req_s reg_req;
    logic [7:0]            rdata;
    logic [7:0]            pins;
    logic [7:0]            is_in;
    logic [7:0]            irq_en;
    logic                  irq_clear = 1'b0;
    logic [1:0]            straps = 2'b10;
    logic [1:0]            ctrl_addr;
    logic                  byte_done;
    logic                  ctrl_valid;
    logic                  ptr_adv;
    logic                  match;
    logic                  slew_en;
    logic                  pend;
    logic                  irq_pin;
    logic                  irq_oe_n;
    int                    n_errors = 0;
    int                    n_checks = 0;
    int                    cycles = 0;

    always #50 clk_i = ~clk_i;

    ioc_compare_cfg #(.SPI_VARIANT(1'b1), .PINS(8), .ADDR_PINS(2)) ioc_compare_cfg_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
        .port_pins_i(pins), .pin_is_input_i(is_in), .change_irq_enable_i(irq_en),
        .irq_clear_i(irq_clear), .byte_done_i(byte_done), .ptr_advance_o(ptr_adv),
        .addr_pins_i(straps), .ctrl_valid_i(ctrl_valid), .ctrl_addr_i(ctrl_addr),
        .addr_match_o(match), .sda_slew_en_o(slew_en), .irq_pending_o(pend),
        .irq_pin_o(irq_pin), .irq_pin_oe_n_o(irq_oe_n)
    );

    host_model host_model_i (
        .clk_i(clk_i), .reg_req_o(reg_req), .reg_rdata_i(rdata), .byte_done_o(byte_done),
        .ctrl_valid_o(ctrl_valid), .ctrl_addr_o(ctrl_addr)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // sample a little after the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model_i.rd(a, d);
        chk(d, exp);
    endtask

    task automatic cfg(input logic [7:0] v);
        host_model_i.wr(ioc_cfg_pkg::ADDR_DEVICE_CONFIG, v);
        settle(2);
    endtask

    // pins pass two synchronising flops first, so allow a short bounded wait
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 8 && pend !== exp; i++)
            settle(1);
        chk(pend, exp);
    endtask

    task automatic clear_irq();
        @(posedge clk_i);
        irq_clear <= 1'b1;
        @(posedge clk_i);
        irq_clear <= 1'b0;
        settle(3);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        pins = 8'h00;
        is_in = 8'hff;
        irq_en = 8'h01;
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle(1);
        chk(slew_en, 8'h01);
        chk({irq_oe_n, irq_pin}, 8'h01);
        rd_chk(ioc_cfg_pkg::ADDR_DEFAULT_COMPARE, 8'h00);
        rd_chk(ioc_cfg_pkg::ADDR_COMPARE_MODE, 8'h00);
        rd_chk(ioc_cfg_pkg::ADDR_DEVICE_CONFIG, 8'h00);
        host_model_i.wr(8'h03, 8'ha5);
        host_model_i.wr(8'h04, 8'h5a);
        rd_chk(8'h03, 8'ha5);
        rd_chk(8'h04, 8'h5a);
        cfg(8'hff);
        rd_chk(8'h05, 8'h3e);
        chk(slew_en, 8'h00);
        rd_chk(8'h06, 8'h00);
        host_model_i.pulse_byte();
        #1 chk(ptr_adv, 8'h00);
        host_model_i.ctrl(2'b10);
        #1 chk(match, 8'h01);
        host_model_i.ctrl(2'b01);
        #1 chk(match, 8'h00);
        // move the straps; they pass two flops before the compare sees them
        @(posedge clk_i);
        straps <= 2'b01;
        settle(2);
        host_model_i.ctrl(2'b01);
        #1 chk(match, 8'h01);
        cfg(8'h00);
        chk(slew_en, 8'h01);
        host_model_i.pulse_byte();
        #1 chk(ptr_adv, 8'h01);
        host_model_i.ctrl(2'b10);
        #1 chk(match, 8'h01);
        // previous-level mode on pin 0: a change raises, the new level becomes the reference
        @(posedge clk_i);
        pins <= 8'h01;
        wait_irq(1'b1);
        clear_irq();
        chk(pend, 8'h00);
        // disabled pins: pin 0 falls and pin 1 mismatches its default, enables all off
        @(posedge clk_i);
        irq_en <= 8'h00;
        pins <= 8'h02;
        settle(6);
        chk(pend, 8'h00);
        // enabled pins that are outputs: pin 0 rises in previous-level mode
        @(posedge clk_i);
        irq_en <= 8'h03;
        is_in <= 8'hfc;
        pins <= 8'h01;
        settle(6);
        chk(pend, 8'h00);
        @(posedge clk_i);
        irq_en <= 8'h01;
        is_in <= 8'hff;
        // default-compare mode: pin 0 high against a default of zero
        host_model_i.wr(8'h03, 8'h00);
        host_model_i.wr(8'h04, 8'h01);
        wait_irq(1'b1);
        clear_irq();
        chk(pend, 8'h01);
        chk({irq_oe_n, irq_pin}, 8'h00);
        cfg(8'h02);
        chk({irq_oe_n, irq_pin}, 8'h01);
        cfg(8'h06);
        chk({irq_oe_n, irq_pin}, 8'h00);
        @(posedge clk_i);
        pins <= 8'h00;
        settle(4);
        clear_irq();
        chk(pend, 8'h00);
        chk({irq_oe_n, irq_pin}, 8'h02);
        cfg(8'h02);
        chk({irq_oe_n, irq_pin}, 8'h00);
        stop_test();
    end
endmodule
